// File: core/hei_pkg.sv
package hei_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_STAT  = 8'h04;
    localparam logic [7:0] OFF_MASK  = 8'h08;
    localparam logic [7:0] OFF_POS   = 8'h0C;
    localparam logic [7:0] OFF_MAXC  = 8'h10;
    localparam logic [7:0] OFF_PULSE = 8'h14;
    localparam logic [7:0] OFF_HCAP  = 8'h18;
    localparam logic [7:0] OFF_HMAX  = 8'h1C;
    localparam logic [7:0] OFF_HRUN  = 8'h20;

    // status / mask bit positions
    localparam int ST_ZCLR = 0;
    localparam int ST_EDGE = 1;
    localparam int ST_WMAX = 2;
    localparam int ST_WRAP = 3;
    localparam int ST_W    = 4;

    // widths of the counters and the control word
    localparam int POS_W  = 16;
    localparam int CNT_W  = 23;
    localparam int CTRL_W = 20;

    // control word, bit 0 at the bottom
    typedef struct packed {
        logic [3:0] filtLen;   // 19:16 filter window in prescaled ticks
        logic [5:0] acmpSel;   // 15:10 comparator index, 2 bits per input
        logic [2:0] srcAcmp;   // 9:7   input takes comparator instead of pin
        logic [2:0] presc;     // 6:4   division 2**presc
        logic       zClrEn;    // 3     index clears position, quadrature mode only
        logic       dirMode;   // 2     pulse plus direction counting
        logic       hallMode;  // 1     hall decoding instead of encoder
        logic       enable;    // 0
    } hei_ctrl_t;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST  = 20'h00000;
    localparam logic [ST_W-1:0]   STAT_RST  = 4'h0;
    localparam logic [ST_W-1:0]   MASK_RST  = 4'h0;
    localparam logic [POS_W-1:0]  POS_RST   = 16'h0000;
    localparam logic [POS_W-1:0]  MAXC_RST  = 16'hFFFF;
    localparam logic [CNT_W-1:0]  CNT_RST   = 23'h000000;
    localparam logic [CNT_W-1:0]  HMAX_RST  = 23'h7FFFFF;

    // latched address phase of a bus transfer
    typedef struct packed {
        logic [7:0] addr;
        logic       write;
        logic       valid;
    } hei_aphase_t;

endpackage

// File: core/hei_position_sensor_interface.sv
`timescale 1ns/100ps
module hei_position_sensor_interface #(
    parameter int NIN   = 3,
    parameter int NACMP = 4,
    parameter int FLT_W = 4
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // sensor pins and comparator outputs
    input  wire logic [NIN-1:0]   sensorInput,
    input  wire logic [NACMP-1:0] analogComparator,
    // interrupt
    output logic             irq
);

    if (NIN != 3 || NACMP != 4 || FLT_W != 4)
    begin : g_chk
        $error("hei: only three inputs, four comparators and 4-bit filter supported");
    end

    // ---------------- registers
    hei_pkg::hei_ctrl_t             ctrl_reg;
    logic [hei_pkg::ST_W-1:0]       stat_reg;
    logic [hei_pkg::ST_W-1:0]       mask_reg;
    logic [hei_pkg::POS_W-1:0]      pos_reg;
    logic [hei_pkg::POS_W-1:0]      maxc_reg;
    logic [hei_pkg::CNT_W-1:0]      pulse_reg;
    logic [hei_pkg::CNT_W-1:0]      hcap_reg;
    logic [hei_pkg::CNT_W-1:0]      hmax_reg;
    logic [hei_pkg::CNT_W-1:0]      hrun_reg;
    logic                           armed_reg;
    hei_pkg::hei_aphase_t           ap_reg;
    logic                           hreadyout_reg;
    logic [31:0]                    hrdata_reg;
    logic                           irq_reg;
    logic [6:0]                     div_reg;
    logic [NIN-1:0]                 pinS1_reg;
    logic [NIN-1:0]                 pinS2_reg;
    logic [NACMP-1:0]               acS1_reg;
    logic [NACMP-1:0]               acS2_reg;
    logic [NIN-1:0]                 filt_reg;
    logic [NIN-1:0]                 filtD_reg;

    // ---------------- bus decode
    logic                           accept;
    logic                           wrEn;
    logic                           rdLoad;
    logic [31:0]                    rdData;
    logic                           wrCtrl;
    logic                           wrStat;
    logic                           wrMask;
    logic                           wrPos;
    logic                           wrMaxc;
    logic                           wrPulse;
    logic                           wrHmax;

    // a read spends one wait state so that it sees any write just before it
    assign accept  = hsel && htrans[1] && hready;
    assign wrEn    = ap_reg.valid && ap_reg.write;
    assign rdLoad  = ap_reg.valid && !ap_reg.write && !hreadyout_reg;
    assign wrCtrl  = wrEn && ap_reg.addr == hei_pkg::OFF_CTRL;
    assign wrStat  = wrEn && ap_reg.addr == hei_pkg::OFF_STAT;
    assign wrMask  = wrEn && ap_reg.addr == hei_pkg::OFF_MASK;
    assign wrPos   = wrEn && ap_reg.addr == hei_pkg::OFF_POS;
    assign wrMaxc  = wrEn && ap_reg.addr == hei_pkg::OFF_MAXC;
    assign wrPulse = wrEn && ap_reg.addr == hei_pkg::OFF_PULSE;
    assign wrHmax  = wrEn && ap_reg.addr == hei_pkg::OFF_HMAX;

    // read mux, unmapped offsets read zero
    assign rdData =
        (ap_reg.addr == hei_pkg::OFF_CTRL)  ? {12'h000, ctrl_reg} :
        (ap_reg.addr == hei_pkg::OFF_STAT)  ? {28'h0000000, stat_reg} :
        (ap_reg.addr == hei_pkg::OFF_MASK)  ? {28'h0000000, mask_reg} :
        (ap_reg.addr == hei_pkg::OFF_POS)   ? {16'h0000, pos_reg} :
        (ap_reg.addr == hei_pkg::OFF_MAXC)  ? {16'h0000, maxc_reg} :
        (ap_reg.addr == hei_pkg::OFF_PULSE) ? {9'h000, pulse_reg} :
        (ap_reg.addr == hei_pkg::OFF_HCAP)  ? {9'h000, hcap_reg} :
        (ap_reg.addr == hei_pkg::OFF_HMAX)  ? {9'h000, hmax_reg} :
        (ap_reg.addr == hei_pkg::OFF_HRUN)  ? {9'h000, hrun_reg} : 32'h00000000;

    // address phase capture and answer
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ap_reg        <= '0;
            hreadyout_reg <= 1'b1;
            hrdata_reg    <= 32'h00000000;
        end
        else
        begin
            if (hreadyout_reg)
            begin
                ap_reg <= '{addr: haddr[7:0], write: hwrite, valid: accept};
            end
            hreadyout_reg <= !(accept && !hwrite && hreadyout_reg);
            if (rdLoad)
            begin
                hrdata_reg <= rdData;
            end
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hrdata    = hrdata_reg;
    assign hresp     = 1'b0;  // always okay

    // ---------------- input synchronisers, pins and comparators are async
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pinS1_reg <= '0;
            pinS2_reg <= '0;
            acS1_reg  <= '0;
            acS2_reg  <= '0;
        end
        else
        begin
            pinS1_reg <= sensorInput;
            pinS2_reg <= pinS1_reg;
            acS1_reg  <= analogComparator;
            acS2_reg  <= acS1_reg;
        end
    end

    // ---------------- prescaler
    logic [6:0] prescTop;
    logic       tick;

    assign prescTop = 7'h7F >> (3'h7 - ctrl_reg.presc);
    assign tick     = div_reg == prescTop;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            div_reg <= 7'h00;
        else if (tick || wrCtrl)
            div_reg <= 7'h00;
        else
            div_reg <= 7'(div_reg + 7'h01);
    end

    // ---------------- source select and filter per input
    logic [NIN-1:0] raw;

    for (genvar i = 0; i < NIN; i++)
    begin : g_in
        logic [FLT_W-1:0] fcnt_reg;
        logic [1:0]       sel;

        assign sel    = ctrl_reg.acmpSel[2*i +: 2];
        assign raw[i] = ctrl_reg.srcAcmp[i] ? acS2_reg[sel] : pinS2_reg[i];

        // a change must hold filtLen+1 ticks before it is taken
        always_ff @(posedge clk_sys or negedge rstn)
        begin
            if (!rstn)
            begin
                fcnt_reg    <= '0;
                filt_reg[i] <= 1'b0;
            end
            else if (tick)
            begin
                if (raw[i] == filt_reg[i])
                    fcnt_reg <= '0;
                else if (fcnt_reg >= ctrl_reg.filtLen)
                begin
                    fcnt_reg    <= '0;
                    filt_reg[i] <= raw[i];
                end
                else
                    fcnt_reg <= FLT_W'(fcnt_reg + 1'b1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            filtD_reg <= '0;
        else
            filtD_reg <= filt_reg;
    end

    // ---------------- edge and mode decode
    logic [NIN-1:0] rise;
    logic [NIN-1:0] chg;
    logic           encOn;
    logic           hallOn;
    logic           quadStep;
    logic           step;
    logic           up;
    logic           zHit;
    logic           wrapEvt;
    logic           hallChg;
    logic           wmaxEvt;

    assign rise     = filt_reg & ~filtD_reg;
    assign chg      = filt_reg ^ filtD_reg;
    assign encOn    = ctrl_reg.enable && !ctrl_reg.hallMode;
    assign hallOn   = ctrl_reg.enable && ctrl_reg.hallMode;
    // both phases moving at once is not a valid quadrature step
    assign quadStep = chg[0] ^ chg[1];
    assign step     = encOn && (ctrl_reg.dirMode ? rise[0] : quadStep);
    assign up       = ctrl_reg.dirMode ? filt_reg[1] : (filt_reg[0] ^ filtD_reg[1]);
    assign zHit     = encOn && !ctrl_reg.dirMode && ctrl_reg.zClrEn && rise[2];
    assign wrapEvt  = step && !up && !zHit && pos_reg == '0;
    assign hallChg  = hallOn && |chg;
    assign wmaxEvt  = hallOn && !hallChg && armed_reg && hrun_reg > hmax_reg;

    // ---------------- encoder counters
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            pos_reg <= hei_pkg::POS_RST;
        else if (wrPos)
            pos_reg <= hwdata[hei_pkg::POS_W-1:0];
        else if (zHit)
            pos_reg <= '0;
        else if (step && up)
            pos_reg <= (pos_reg == maxc_reg) ? '0 : 16'(pos_reg + 16'h0001);
        else if (step)
            pos_reg <= wrapEvt ? maxc_reg : 16'(pos_reg - 16'h0001);
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            pulse_reg <= hei_pkg::CNT_RST;
        else if (wrPulse)
            pulse_reg <= hwdata[hei_pkg::CNT_W-1:0];
        else if (encOn && rise[0])
            pulse_reg <= 23'(pulse_reg + 23'h000001);
    end

    // ---------------- hall width timer, saturates instead of wrapping
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            hrun_reg  <= hei_pkg::CNT_RST;
            hcap_reg  <= hei_pkg::CNT_RST;
            armed_reg <= 1'b0;
        end
        else if (hallChg)
        begin
            hcap_reg  <= hrun_reg;
            hrun_reg  <= '0;
            armed_reg <= 1'b1;
        end
        else
        begin
            if (hallOn && tick && !(&hrun_reg))
                hrun_reg <= 23'(hrun_reg + 23'h000001);
            if (wmaxEvt)
                armed_reg <= 1'b0;  // one alarm per edge
        end
    end

    // ---------------- configuration registers
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_reg <= hei_pkg::CTRL_RST;
            mask_reg <= hei_pkg::MASK_RST;
            maxc_reg <= hei_pkg::MAXC_RST;
            hmax_reg <= hei_pkg::HMAX_RST;
        end
        else
        begin
            if (wrCtrl)
                ctrl_reg <= hwdata[hei_pkg::CTRL_W-1:0];
            if (wrMask)
                mask_reg <= hwdata[hei_pkg::ST_W-1:0];
            if (wrMaxc)
                maxc_reg <= hwdata[hei_pkg::POS_W-1:0];
            if (wrHmax)
                hmax_reg <= hwdata[hei_pkg::CNT_W-1:0];
        end
    end

    // ---------------- sticky status, write one to clear, new event wins
    logic [hei_pkg::ST_W-1:0] evt;
    logic [hei_pkg::ST_W-1:0] clr;

    assign evt = {wrapEvt, wmaxEvt, hallChg, zHit};
    assign clr = wrStat ? hwdata[hei_pkg::ST_W-1:0] : '0;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            stat_reg <= hei_pkg::STAT_RST;
            irq_reg  <= 1'b0;
        end
        else
        begin
            stat_reg <= (stat_reg & ~clr) | evt;
            irq_reg  <= |(stat_reg & mask_reg);  // one cycle behind status
        end
    end

    assign irq = irq_reg;

    // ---------------- checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    // checks the counters themselves, not the decode that gates them
    property p_modeExcl;
        (hallOn && !wrPos && !wrPulse) |=> $stable(pos_reg) && $stable(pulse_reg);
    endproperty
    a_modeExcl: assert property (p_modeExcl) else $error("encoder counted in hall mode");

    property p_prescRun;
        (!tick && !wrCtrl) |=> div_reg == 7'($past(div_reg) + 7'h01);
    endproperty
    a_prescRun: assert property (p_prescRun) else $error("prescaler did not advance");

    property p_filtTick;
        $changed(filt_reg) |-> $past(tick);
    endproperty
    a_filtTick: assert property (p_filtTick) else $error("filter moved off a tick");

    property p_posUp;
        (step && up && !wrPos && !zHit && pos_reg != maxc_reg)
            |=> pos_reg == 16'($past(pos_reg) + 16'h0001);
    endproperty
    a_posUp: assert property (p_posUp) else $error("position did not count up");

    property p_posDown;
        (step && !up && !wrPos && !zHit && pos_reg != '0)
            |=> pos_reg == 16'($past(pos_reg) - 16'h0001);
    endproperty
    a_posDown: assert property (p_posDown) else $error("position did not count down");

    property p_zClear;
        (zHit && !wrPos) |=> pos_reg == '0 && stat_reg[hei_pkg::ST_ZCLR];
    endproperty
    a_zClear: assert property (p_zClear) else $error("index did not clear position");

    property p_reload;
        (wrapEvt && !wrPos) |=> pos_reg == $past(maxc_reg) && stat_reg[hei_pkg::ST_WRAP];
    endproperty
    a_reload: assert property (p_reload) else $error("underflow did not reload maximum");

    property p_pulse;
        (encOn && rise[0] && !wrPulse) |=> pulse_reg == 23'($past(pulse_reg) + 23'h000001);
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse not counted");

    property p_hallCap;
        hallChg |=> hcap_reg == $past(hrun_reg) && hrun_reg == '0
            && stat_reg[hei_pkg::ST_EDGE];
    endproperty
    a_hallCap: assert property (p_hallCap) else $error("hall edge not captured");

    property p_hallMax;
        (hallOn && armed_reg && !hallChg && hrun_reg > hmax_reg)
            |=> stat_reg[hei_pkg::ST_WMAX] && !armed_reg;
    endproperty
    a_hallMax: assert property (p_hallMax) else $error("width alarm missing");

    property p_setWins;
        (|(evt & clr)) |=> (stat_reg & $past(evt)) == $past(evt);
    endproperty
    a_setWins: assert property (p_setWins) else $error("event lost under clear");

endmodule

// File: dv/hei_sensor_model.sv
`timescale 1ns/100ps
module hei_sensor_model (
    // clock the pins are stepped against
    input  wire logic clk_sys,
    // sensor pins and comparator outputs
    output logic [2:0] sensorPins,
    output logic [3:0] comparatorOut
);
    logic [1:0] phase;

    // pins and comparators start low
    initial
    begin
        sensorPins    = 3'h0;
        comparatorOut = 4'h0;
        phase         = 2'h0;
    end

    // level moves one edge on, then holds n cycles, past the filter window
    task automatic drive(input logic [2:0] p, input int n);
        @(posedge clk_sys);
        sensorPins <= p;
        repeat (n) @(posedge clk_sys);
    endtask

    // one gray step, a leads b going up; index line left alone
    task automatic quad(input logic up, input int n);
        phase = up ? phase + 2'h1 : phase - 2'h1;
        drive({sensorPins[2], phase[1], phase[1] ^ phase[0]}, n);
    endtask

    // high for hi cycles, then low for lo cycles
    task automatic pulse(input int i, input int hi, input int lo);
        drive(sensorPins | (3'h1 << i), hi);
        drive(sensorPins & ~(3'h1 << i), lo);
    endtask

    // comparator outputs follow the same holding discipline
    task automatic cmp(input int i, input logic v, input int n);
        @(posedge clk_sys);
        comparatorOut[i] <= v;
        repeat (n) @(posedge clk_sys);
    endtask
endmodule

// File: dv/hei_position_sensor_interface_test.sv
`timescale 1ns/100ps
module hei_position_sensor_interface_test;
    logic        clk_sys;
    logic        rstn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic [2:0]  sensorPins;
    logic [3:0]  cmpOut;
    logic        irq;
    logic [31:0] rd;
    logic [31:0] a;
    int          errCount;
    int          checksDone;

    // 25 MHz system clock
    initial clk_sys = 1'b0;
    always #20 clk_sys = ~clk_sys;

    hei_position_sensor_interface hei_position_sensor_interface_i (
        .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .sensorInput(sensorPins), .analogComparator(cmpOut), .irq(irq)
    );

    hei_sensor_model hei_sensor_model_i (
        .clk_sys(clk_sys), .sensorPins(sensorPins), .comparatorOut(cmpOut)
    );

    // one single word transfer; only the watchdog ends a wait on a stuck slave
    task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h000000, ad};
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // exact comparison
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checksDone++;
        if (got !== exp)
        begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // timed counts may land up to tol ticks either side of the ideal figure
    task automatic checkNear(input string nm, input logic [31:0] exp,
                             input logic [31:0] got, input int tol);
        checksDone++;
        if ((^got === 1'bx) || got > exp + tol || got + tol < exp)
        begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic readCheck(input string nm, input logic [7:0] ad, input logic [31:0] exp);
        xfer(1'b0, ad, 32'h00000000);
        check(nm, exp, rd);
    endtask

    task automatic reportAndStop;
        $display("comparisons %0d mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // main sequence
    initial
    begin
        rstn       = 1'b0;
        hsel       = 1'b0;
        haddr      = 32'h00000000;
        htrans     = 2'h0;
        hwrite     = 1'b0;
        hsize      = 3'h2;
        hwdata     = 32'h00000000;
        errCount   = 0;
        checksDone = 0;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        xfer(1'b1, 8'h24, 32'hFFFFFFFF);
        readCheck("hole", 8'h24, 32'h00000000);
        readCheck("ctrl", hei_pkg::OFF_CTRL, {12'h000, hei_pkg::CTRL_RST});
        readCheck("stat", hei_pkg::OFF_STAT, {28'h0000000, hei_pkg::STAT_RST});
        readCheck("mask", hei_pkg::OFF_MASK, {28'h0000000, hei_pkg::MASK_RST});
        readCheck("pos", hei_pkg::OFF_POS, {16'h0000, hei_pkg::POS_RST});
        readCheck("maxc", hei_pkg::OFF_MAXC, {16'h0000, hei_pkg::MAXC_RST});
        readCheck("pulse", hei_pkg::OFF_PULSE, {9'h000, hei_pkg::CNT_RST});
        readCheck("hmax", hei_pkg::OFF_HMAX, {9'h000, hei_pkg::HMAX_RST});
        check("irq", 32'h0, {31'h0, irq});
        check("hresp", 32'h0, {31'h0, hresp});
        $display("test reset done");
        // quadrature up, then down through zero onto the maximum
        xfer(1'b1, hei_pkg::OFF_MAXC, 32'h00000010);
        xfer(1'b1, hei_pkg::OFF_CTRL, 32'h00000001);
        repeat (4) hei_sensor_model_i.quad(1'b1, 8);
        readCheck("pos up", hei_pkg::OFF_POS, 32'h00000004);
        readCheck("pulse", hei_pkg::OFF_PULSE, 32'h00000001);
        repeat (6) hei_sensor_model_i.quad(1'b0, 8);
        readCheck("pos wrap", hei_pkg::OFF_POS, 32'h0000000F);
        readCheck("stat wrap", hei_pkg::OFF_STAT, 32'h00000008);
        xfer(1'b1, hei_pkg::OFF_MASK, 32'h00000008);
        repeat (3) @(posedge clk_sys);
        check("irq on", 32'h1, {31'h0, irq});
        xfer(1'b1, hei_pkg::OFF_STAT, 32'h00000008);
        repeat (3) @(posedge clk_sys);
        check("irq off", 32'h0, {31'h0, irq});
        readCheck("stat w1c", hei_pkg::OFF_STAT, 32'h00000000);
        $display("test quadrature done");
        // index pulse clears the position
        xfer(1'b1, hei_pkg::OFF_CTRL, 32'h00000009);
        hei_sensor_model_i.pulse(2, 8, 8);
        readCheck("pos index", hei_pkg::OFF_POS, 32'h00000000);
        readCheck("stat index", hei_pkg::OFF_STAT, 32'h00000001);
        $display("test index done");
        // pulse plus direction counting
        xfer(1'b1, hei_pkg::OFF_CTRL, 32'h00000005);
        hei_sensor_model_i.drive(3'h0, 8);
        xfer(1'b1, hei_pkg::OFF_POS, 32'h00000005);
        xfer(1'b1, hei_pkg::OFF_PULSE, 32'h00000000);
        hei_sensor_model_i.drive(3'h2, 8);
        repeat (2) hei_sensor_model_i.pulse(0, 8, 8);
        readCheck("pos dir up", hei_pkg::OFF_POS, 32'h00000007);
        hei_sensor_model_i.drive(3'h0, 8);
        repeat (3) hei_sensor_model_i.pulse(0, 8, 8);
        readCheck("pos dir down", hei_pkg::OFF_POS, 32'h00000004);
        readCheck("pulse dir", hei_pkg::OFF_PULSE, 32'h00000005);
        $display("test direction done");
        // a glitch inside the window is dropped, a long pulse counts
        xfer(1'b1, hei_pkg::OFF_CTRL, 32'h00030005);
        hei_sensor_model_i.pulse(0, 2, 12);
        readCheck("glitch", hei_pkg::OFF_PULSE, 32'h00000005);
        hei_sensor_model_i.pulse(0, 12, 12);
        readCheck("long pulse", hei_pkg::OFF_PULSE, 32'h00000006);
        $display("test filter done");
        // running hall width over 1027 cycles at every division ratio
        for (int p = 0; p < 8; p++)
        begin
            xfer(1'b1, hei_pkg::OFF_CTRL, 32'h00000003 | (p << 4));
            xfer(1'b0, hei_pkg::OFF_HRUN, 32'h00000000);
            a = rd;
            repeat (1024) @(posedge clk_sys);
            xfer(1'b0, hei_pkg::OFF_HRUN, 32'h00000000);
            checkNear("hall run", 32'h00000403 >> p, rd - a, 1);
        end
        $display("test prescaler done");
        // hall edges, width capture and the width alarm
        xfer(1'b1, hei_pkg::OFF_CTRL, 32'h00000003);
        xfer(1'b1, hei_pkg::OFF_HMAX, 32'h00000040);
        repeat (4) @(posedge clk_sys);
        xfer(1'b1, hei_pkg::OFF_STAT, 32'h0000000F);
        xfer(1'b1, hei_pkg::OFF_MASK, 32'h00000006);
        hei_sensor_model_i.drive(3'h1, 30);
        hei_sensor_model_i.drive(3'h3, 100);
        xfer(1'b0, hei_pkg::OFF_HCAP, 32'h00000000);
        checkNear("hall capture", 32'd31, rd, 2);
        readCheck("stat hall", hei_pkg::OFF_STAT, 32'h00000006);
        check("irq hall", 32'h1, {31'h0, irq});
        // the long filter pulse stepped down once with direction low
        readCheck("pos frozen", hei_pkg::OFF_POS, 32'h00000003);
        xfer(1'b1, hei_pkg::OFF_STAT, 32'h00000006);
        repeat (3) @(posedge clk_sys);
        check("irq hall off", 32'h0, {31'h0, irq});
        $display("test hall done");
        // input 0 taken from each comparator in turn
        hei_sensor_model_i.drive(3'h0, 8);
        for (int c = 0; c < 4; c++)
        begin
            xfer(1'b1, hei_pkg::OFF_CTRL, 32'h00000083 | (c << 10));
            xfer(1'b1, hei_pkg::OFF_STAT, 32'h0000000F);
            hei_sensor_model_i.cmp(c, 1'b1, 12);
            xfer(1'b0, hei_pkg::OFF_STAT, 32'h00000000);
            check("comparator edge", 32'h00000002, rd & 32'h00000002);
            hei_sensor_model_i.cmp(c, 1'b0, 12);
        end
        $display("test comparator done");
        reportAndStop;
    end

    // the whole run needs about 9000 cycles
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        errCount++;
        $display("watchdog expired");
        reportAndStop;
    end
endmodule
